// *** logic/prs_pkg.sv ***
// Package of constants and types for the memory power-up and reset sequencer.
package prs_pkg;
  localparam int CLK_PERIOD_PS = 20000;
  // Times as printed, in their own units.
  localparam int POWER_UP_WAIT_MAX_US = 150;
  localparam int POWER_UP_WAIT_MIN_US = 1;
  localparam int RESET_PULSE_WIDTH_NS = 200;
  localparam int RESET_HIGH_TO_SELECT_NS = 200;
  localparam int RESET_LOW_TO_SELECT_NS = 400;
  localparam int SUPPLY_LOW_DURATION_US = 50;
  // Least times round up, longest times round down.
  localparam int POWER_UP_WAIT_CYC = (POWER_UP_WAIT_MAX_US * 1000000) / CLK_PERIOD_PS;
  localparam int POWER_UP_MIN_CYC =
    (POWER_UP_WAIT_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_WIDTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RESET_HIGH_CYC = (RESET_HIGH_TO_SELECT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RESET_LOW_CYC = (RESET_LOW_TO_SELECT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SUPPLY_LOW_CYC = (SUPPLY_LOW_DURATION_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 16;
  localparam int ROW_W = 13;
  localparam int CFG_W = 16;
  localparam logic [ROW_W-1:0] ROW_RESET = 13'h0000;
  localparam logic [CFG_W-1:0] CFG_RESET = 16'h8F1F;

  typedef enum logic [2:0] {
    PRS_DEV_OFF     = 3'b000,
    PRS_DEV_RESET   = 3'b001,
    PRS_DEV_INIT    = 3'b010,
    PRS_DEV_STANDBY = 3'b011,
    PRS_DEV_ACTIVE  = 3'b100,
    PRS_DEV_SLEEP   = 3'b101,
    PRS_DEV_DPD     = 3'b110
  } prs_dev_state_t;

  typedef enum logic [2:0] {
    PRS_HST_PWR    = 3'b000,
    PRS_HST_PUWAIT = 3'b001,
    PRS_HST_READY  = 3'b010,
    PRS_HST_RSTLOW = 3'b011,
    PRS_HST_RSTHI  = 3'b100,
    PRS_HST_BUSY   = 3'b101
  } prs_hst_state_t;
endpackage

// *** logic/prs_link_if.sv ***
// Interface joining the memory end and the host controller end.
`timescale 1ns/1ps
interface prs_link_if;
  logic cs_n;
  logic reset_n;
  logic supply_ok;
  modport device (input cs_n, input reset_n, input supply_ok);
  modport host   (output cs_n, output reset_n, input supply_ok);
endinterface

// *** logic/prs_sync3.sv ***
// Three-stage synchroniser that reports a change once stages two and three agree.
`timescale 1ns/1ps
module prs_sync3 #(
  parameter logic INIT = 1'b1
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Asynchronous level in, filtered level out.
  input  wire logic d,
  output logic      q
);
  logic [2:0] st_reg;
  logic [2:0] st_next;
  logic       q_reg;
  logic       q_next;

  always_comb begin
    st_next = {st_reg[1:0], d};
    q_next  = (st_reg[1] == st_reg[2]) ? st_reg[2] : q_reg;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= {3{INIT}};
      q_reg  <= INIT;
    end else begin
      st_reg <= st_next;
      q_reg  <= q_next;
    end
  end

  assign q = q_reg;
endmodule

// *** logic/prs_device.sv ***
// Memory end: power-up initialisation, hardware reset and low-power state exit.
// Function
// [RULE1] Finish self-initialisation within the power-up wait.
// [RULE2] Host keeps select high during power-up wait.
// [RULE3] Reset low at power-up delays the wait.
// [RULE4] Refresh the array during the power-up wait.
// [RULE5] Host issues no access during power-up wait.
// [RULE6] Host resets after a short supply dip.
// [RULE7] Reset low returns device to standby.
// [RULE8] Reset restores configuration registers to defaults.
// [RULE9] Reset exits hybrid sleep and deep power-down.
// [RULE10] Reset halts refresh, clears row counter, invalidates.
// [RULE11] Host idle during reset pulse and after.
// [RULE12] Host waits 400 ns from reset fall.
// [RULE13] Host waits 200 ns from reset rise.
// [RULE14] Host treats array contents lost after reset.
// [RULE15] Host counts intervals in cycles, rounded up.
`timescale 1ns/1ps
module prs_device
  import prs_pkg::*;
#(
  parameter int POWER_UP_CYCLES = POWER_UP_WAIT_CYC
) (
  // Clock and reset.
  input  wire logic        REF_CLK,
  input  wire logic        RESET,
  // Link to the host.
  prs_link_if.device       LINK,
  // Low-power requests and configuration writes from the transaction logic.
  input  wire logic        SLEEP_REQ,
  input  wire logic        DPD_REQ,
  input  wire logic        CFG_WE,
  input  wire logic [CFG_W-1:0] CFG_WDATA,
  // Status.
  output logic             READY,
  output logic             REFRESHING,
  output logic             ARRAY_VALID,
  output logic             ACCESS_ERR,
  output logic [ROW_W-1:0] REFRESH_ROW,
  output logic [CFG_W-1:0] CFG_VALUE,
  output logic [2:0]       STATE
);
  logic cs_n_s;
  logic rst_n_s;
  logic pwr_s;

  prs_sync3 #(.INIT(1'b1)) u_cs  (.clk(REF_CLK), .rst(RESET), .d(LINK.cs_n),      .q(cs_n_s));
  prs_sync3 #(.INIT(1'b0)) u_rst (.clk(REF_CLK), .rst(RESET), .d(LINK.reset_n),   .q(rst_n_s));
  prs_sync3 #(.INIT(1'b0)) u_pwr (.clk(REF_CLK), .rst(RESET), .d(LINK.supply_ok), .q(pwr_s));

  prs_dev_state_t   state_reg,  state_next;
  logic [CNT_W-1:0] cnt_reg,    cnt_next;
  logic [ROW_W-1:0] row_reg,    row_next;
  logic [CFG_W-1:0] cfg_reg,    cfg_next;
  logic             valid_reg,  valid_next;
  logic             err_reg,    err_next;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    row_next   = row_reg;
    cfg_next   = cfg_reg;
    valid_next = valid_reg;
    err_next   = 1'b0;
    if (!pwr_s) begin
      state_next = PRS_DEV_OFF;
      cfg_next   = CFG_RESET;
      row_next   = ROW_RESET;
      valid_next = 1'b0;
    end else if (!rst_n_s) begin
      // A reset held through power-up keeps the device uninitialised, so the wait runs later.
      if (state_reg == PRS_DEV_OFF || state_reg == PRS_DEV_INIT) begin
        state_next = PRS_DEV_OFF; // [RULE3]
      end else begin
        state_next = PRS_DEV_RESET; // [RULE7]
      end
      cfg_next   = CFG_RESET; // [RULE8]
      row_next   = ROW_RESET; // [RULE10]
      valid_next = 1'b0; // [RULE10]
      cnt_next   = '0;
      err_next   = !cs_n_s;
    end else begin
      unique case (state_reg)
        PRS_DEV_OFF: begin
          state_next = PRS_DEV_INIT; // [RULE3]
          cnt_next   = '0;
        end
        PRS_DEV_RESET: begin
          state_next = PRS_DEV_STANDBY; // [RULE10]
        end
        PRS_DEV_INIT: begin
          row_next = row_reg + 1'b1; // [RULE4]
          err_next = !cs_n_s;
          if (cnt_reg >= CNT_W'(POWER_UP_CYCLES - 1)) begin
            state_next = PRS_DEV_STANDBY; // [RULE1]
            valid_next = 1'b1;
          end else begin
            cnt_next = cnt_reg + 1'b1;
          end
        end
        PRS_DEV_STANDBY: begin
          row_next = row_reg + 1'b1;
          if (CFG_WE) begin
            cfg_next = CFG_WDATA;
          end
          if (!cs_n_s) begin
            state_next = PRS_DEV_ACTIVE;
            valid_next = 1'b1;
          end else if (DPD_REQ) begin
            state_next = PRS_DEV_DPD;
            valid_next = 1'b0;
          end else if (SLEEP_REQ) begin
            state_next = PRS_DEV_SLEEP;
          end
        end
        PRS_DEV_ACTIVE: begin
          row_next = row_reg + 1'b1;
          if (cs_n_s) begin
            state_next = PRS_DEV_STANDBY;
          end
        end
        PRS_DEV_SLEEP: begin
          row_next = row_reg + 1'b1;
          if (!cs_n_s) begin
            state_next = PRS_DEV_STANDBY;
          end
        end
        PRS_DEV_DPD: begin
          if (!cs_n_s) begin
            state_next = PRS_DEV_INIT;
            cnt_next   = '0;
          end
        end
        default: begin
          state_next = PRS_DEV_OFF;
        end
      endcase
    end
  end

  // A reset low forces every state but off, sleep and deep power-down included, back out.
  always_ff @(posedge REF_CLK or posedge RESET) begin // [RULE9]
    if (RESET) begin
      state_reg <= PRS_DEV_OFF;
      cnt_reg   <= '0;
      row_reg   <= ROW_RESET;
      cfg_reg   <= CFG_RESET;
      valid_reg <= 1'b0;
      err_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      row_reg   <= row_next;
      cfg_reg   <= cfg_next;
      valid_reg <= valid_next;
      err_reg   <= err_next;
    end
  end

  assign READY       = (state_reg == PRS_DEV_STANDBY) || (state_reg == PRS_DEV_ACTIVE);
  assign REFRESHING  = (state_reg == PRS_DEV_INIT) || (state_reg == PRS_DEV_STANDBY) ||
                       (state_reg == PRS_DEV_ACTIVE) || (state_reg == PRS_DEV_SLEEP);
  assign ARRAY_VALID = valid_reg;
  assign ACCESS_ERR  = err_reg;
  assign REFRESH_ROW = row_reg;
  assign CFG_VALUE   = cfg_reg;
  assign STATE       = state_reg;
endmodule

// *** logic/prs_host.sv ***
// Host end: drives chip select and reset while honouring every waiting period.
`timescale 1ns/1ps
module prs_host
  import prs_pkg::*;
#(
  parameter int POWER_UP_CYCLES = POWER_UP_WAIT_CYC
) (
  // Clock and reset.
  input  wire logic  REF_CLK,
  input  wire logic  RESET,
  // Link to the memory.
  prs_link_if.host   LINK,
  // User requests.
  input  wire logic  RESET_REQ,
  input  wire logic  DIP_SEEN,
  input  wire logic  ACCESS_REQ,
  input  wire logic  ACCESS_DONE,
  // Status.
  output logic       ACCESS_GNT,
  output logic       BUS_READY,
  output logic       DATA_LOST
);
  logic pwr_s;

  prs_sync3 #(.INIT(1'b0)) u_pwr (.clk(REF_CLK), .rst(RESET), .d(LINK.supply_ok), .q(pwr_s));

  prs_hst_state_t   state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg,   cnt_next;
  logic             lost_reg,  lost_next;
  logic             cs_reg,    cs_next;
  logic             rst_reg,   rst_next;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg + 1'b1;
    lost_next  = lost_reg;
    cs_next    = 1'b1;
    rst_next   = 1'b1;
    if (!pwr_s) begin
      state_next = PRS_HST_PWR; // [RULE2]
      cnt_next   = '0;
    end else begin
      unique case (state_reg)
        PRS_HST_PWR: begin
          state_next = PRS_HST_PUWAIT;
          cnt_next   = '0;
        end
        PRS_HST_PUWAIT: begin
          if (cnt_reg >= CNT_W'(POWER_UP_CYCLES - 1)) begin // [RULE5]
            state_next = PRS_HST_READY; // [RULE15]
          end
        end
        PRS_HST_READY: begin
          if (RESET_REQ || DIP_SEEN) begin
            state_next = PRS_HST_RSTLOW; // [RULE6]
            cnt_next   = '0;
            rst_next   = 1'b0;
          end else if (ACCESS_REQ) begin
            state_next = PRS_HST_BUSY;
            cs_next    = 1'b0;
          end
        end
        PRS_HST_BUSY: begin
          cs_next = 1'b0;
          if (ACCESS_DONE) begin
            state_next = PRS_HST_READY;
            cs_next    = 1'b1;
          end
        end
        PRS_HST_RSTLOW: begin
          rst_next = 1'b0;
          if (cnt_reg >= CNT_W'(RESET_PULSE_CYC - 1)) begin // [RULE11]
            state_next = PRS_HST_RSTHI;
            rst_next   = 1'b1;
            cnt_next   = '0;
          end
        end
        PRS_HST_RSTHI: begin
          if (cnt_reg >= CNT_W'(RESET_HIGH_CYC - 1) &&
              cnt_reg >= CNT_W'(RESET_LOW_CYC - RESET_PULSE_CYC - 1)) begin // [RULE12] [RULE13]
            state_next = PRS_HST_READY;
            lost_next  = 1'b1; // [RULE14]
          end
        end
        default: begin
          state_next = PRS_HST_PWR;
        end
      endcase
    end
    if (ACCESS_REQ && state_next == PRS_HST_BUSY) begin
      lost_next = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      state_reg <= PRS_HST_PWR;
      cnt_reg   <= '0;
      lost_reg  <= 1'b0;
      cs_reg    <= 1'b1;
      rst_reg   <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      lost_reg  <= lost_next;
      cs_reg    <= cs_next;
      rst_reg   <= rst_next;
    end
  end

  assign LINK.cs_n    = cs_reg;
  assign LINK.reset_n = rst_reg;
  assign ACCESS_GNT   = (state_reg == PRS_HST_BUSY);
  assign BUS_READY    = (state_reg == PRS_HST_READY);
  assign DATA_LOST    = lost_reg;
endmodule

// *** test/prs_properties.sv ***
// Timing checks on the link between the host end and the memory end.
`timescale 1ns/1ps
module prs_properties
  import prs_pkg::*;
#(
  parameter int POWER_UP_CYCLES = POWER_UP_WAIT_CYC
) (
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RESET,
  // Link.
  input wire logic cs_n,
  input wire logic reset_n,
  input wire logic supply_ok
);
  localparam int PULSE_LAST = RESET_PULSE_CYC - 1;
  logic [15:0] pu_reg, lo_reg, fall_reg, rise_reg;
  logic [15:0] pu_next, lo_next, fall_next, rise_next;
  logic        rn_reg;
  always_comb begin
    pu_next   = pu_reg + {15'h0000, supply_ok && pu_reg != 16'hFFFF};
    lo_next   = reset_n ? 16'h0000 : lo_reg + 16'h0001;
    fall_next = (rn_reg && !reset_n) ? 16'h0001 : fall_reg + {15'h0000, fall_reg != 16'hFFFF};
    rise_next = (!rn_reg && reset_n) ? 16'h0001 : rise_reg + {15'h0000, rise_reg != 16'hFFFF};
  end
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      pu_reg   <= 16'h0000;
      lo_reg   <= 16'h0000;
      fall_reg <= 16'hFFFF;
      rise_reg <= 16'hFFFF;
      rn_reg   <= 1'b1;
    end else begin
      pu_reg   <= pu_next;
      lo_reg   <= lo_next;
      fall_reg <= fall_next;
      rise_reg <= rise_next;
      rn_reg   <= reset_n;
    end
  end
  default clocking dc @(posedge REF_CLK);
  endclocking
  default disable iff (RESET);
  chk_pu_select_high: assert property (pu_reg < POWER_UP_CYCLES |-> cs_n)
    else $error("select low in power-up wait");
  chk_pulse_min: assert property ($rose(reset_n) |-> lo_reg >= RESET_PULSE_CYC)
    else $error("reset pulse short");
  chk_pulse_exact: assert property ($fell(reset_n) |-> ##PULSE_LAST !reset_n ##1 reset_n)
    else $error("reset pulse length");
  chk_select_in_reset: assert property (!reset_n |-> cs_n)
    else $error("select low in reset");
  chk_fall_to_select: assert property ($fell(cs_n) |-> fall_reg >= RESET_LOW_CYC)
    else $error("select early after reset fall");
  chk_fall_window: assert property (fall_reg < RESET_LOW_CYC |-> cs_n)
    else $error("select inside reset window");
  chk_rise_to_select: assert property ($fell(cs_n) |-> rise_reg >= RESET_HIGH_CYC)
    else $error("select early after reset rise");
  chk_rise_hold: assert property ($rose(reset_n) |-> cs_n [*8])
    else $error("select low after reset rise");
endmodule

// *** test/tb_top.sv ***
// Self-checking bench for the host end facing the memory end.
`timescale 1ns/1ps
module tb_top;
  import prs_pkg::*;
  localparam int PU = 60;
  logic             REF_CLK = 1'b0;
  logic             RESET = 1'b1;
  logic             rst_req = 1'b0, dip = 1'b0, acc_req = 1'b0, acc_done = 1'b0;
  logic             slp = 1'b0, dpd = 1'b0, cfg_we = 1'b0;
  logic [CFG_W-1:0] cfg_wd = 16'h0000;
  logic             rdy, rfr, valid, err, gnt, bus_rdy, lost, rdy_b;
  logic [ROW_W-1:0] row;
  logic [CFG_W-1:0] cfg;
  logic [2:0]       st;
  int               bad_count = 0, checks = 0, cycles = 0;
  prs_link_if link ();
  prs_link_if link_b ();
  always #10 REF_CLK = ~REF_CLK;
  prs_device #(.POWER_UP_CYCLES(PU)) i_prs_device (.REF_CLK(REF_CLK), .RESET(RESET),
    .LINK(link.device), .SLEEP_REQ(slp), .DPD_REQ(dpd), .CFG_WE(cfg_we), .CFG_WDATA(cfg_wd),
    .READY(rdy), .REFRESHING(rfr), .ARRAY_VALID(valid), .ACCESS_ERR(err), .REFRESH_ROW(row),
    .CFG_VALUE(cfg), .STATE(st));
  // Second memory end, its link driven by the bench to hold reset low at power-up.
  prs_device #(.POWER_UP_CYCLES(PU)) i_prs_device_b (.REF_CLK(REF_CLK), .RESET(RESET),
    .LINK(link_b.device), .SLEEP_REQ(1'b0), .DPD_REQ(1'b0), .CFG_WE(1'b0),
    .CFG_WDATA(16'h0000), .READY(rdy_b), .REFRESHING(), .ARRAY_VALID(), .ACCESS_ERR(),
    .REFRESH_ROW(), .CFG_VALUE(), .STATE());
  prs_host #(.POWER_UP_CYCLES(PU)) i_prs_host (.REF_CLK(REF_CLK), .RESET(RESET),
    .LINK(link.host), .RESET_REQ(rst_req), .DIP_SEEN(dip), .ACCESS_REQ(acc_req),
    .ACCESS_DONE(acc_done), .ACCESS_GNT(gnt), .BUS_READY(bus_rdy), .DATA_LOST(lost));
  prs_properties #(.POWER_UP_CYCLES(PU)) i_prs_properties (.REF_CLK(REF_CLK),
    .RESET(RESET), .cs_n(link.cs_n), .reset_n(link.reset_n), .supply_ok(link.supply_ok));
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask
  // One-cycle pulse on reset request, dip, access request or access done.
  task automatic drive(input int k);
    @(posedge REF_CLK);
    {acc_done, acc_req, dip, rst_req} <= 4'h1 << k;
    @(posedge REF_CLK);
    {acc_done, acc_req, dip, rst_req} <= 4'h0;
  endtask
  task automatic access(input int hold);
    drive(2);
    #1;
    cmp(gnt, 1);
    cmp(link.cs_n, 0);
    drive(0);
    tick(hold);
    cmp(link.reset_n, 1);
    drive(3);
    tick(1);
    cmp(link.cs_n, 1);
    cmp(lost, 0);
  endtask
  always @(posedge REF_CLK) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      $display("[FAIL] %0t timeout", $time);
      wrap_up();
    end
  end
  initial begin
    link.supply_ok = 1'b0;
    link_b.supply_ok = 1'b1;
    link_b.reset_n = 1'b0;
    link_b.cs_n = 1'b1;
    repeat (20) @(posedge REF_CLK);
    RESET <= 1'b0;
    tick(50);
    cmp(rdy, 0);
    @(posedge REF_CLK);
    link.supply_ok <= 1'b1;
    link_b.reset_n <= 1'b1;
    tick(50);
    cmp(rdy, 0);
    cmp(rdy_b, 0);
    cmp(rfr, 1);
    cmp(link.cs_n, 1);
    tick(20);
    cmp(rdy, 1);
    cmp(rdy_b, 1);
    cmp(bus_rdy, 1);
    cmp(cfg, CFG_RESET);
    access(2);
    for (int m = 0; m < 2; m++) begin
      // Let the memory end see select high and fall back to standby first.
      tick(6);
      @(posedge REF_CLK);
      cfg_we <= 1'b1;
      cfg_wd <= 16'h1234;
      @(posedge REF_CLK);
      cfg_we <= 1'b0;
      slp <= (m == 0);
      dpd <= (m == 1);
      tick(4);
      cmp(cfg, 16'h1234);
      cmp(st, m ? PRS_DEV_DPD : PRS_DEV_SLEEP);
      drive(m);
      slp <= 1'b0;
      dpd <= 1'b0;
      wait (link.reset_n === 1'b0);
      tick(6);
      cmp(st, PRS_DEV_RESET);
      cmp(rfr, 0);
      cmp(valid, 0);
      cmp(row, ROW_RESET);
      wait (link.reset_n === 1'b1);
      tick(8);
      cmp(st, PRS_DEV_STANDBY);
      cmp(cfg, CFG_RESET);
      cmp(rfr, 1);
      cmp(bus_rdy, 0);
      tick(4);
      cmp(lost, 1);
      access(m + 2);
    end
    cmp(err, 0);
    wrap_up();
  end
endmodule
